// ---- logic/act_cfg.svh ----
/*
 Constants of the converter compute and threshold unit: widths, register
 offsets, field positions, mode codes and timing counts.
 Assumes it is included by bare name, before the package and the unit.
*/
`ifndef ACT_CFG_SVH
`define ACT_CFG_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define ACT_RES_W    10
`define ACT_ACC_W    18
`define ACT_DW       16
`define ACT_AW       8
`define ACT_BIT_MSB  4'h9
// ----------------------------------------
// Timing: four clocks per instruction cycle, three clocks per conversion bit
// ----------------------------------------
`define ACT_DIV_LAST 2'h3
`define ACT_BIT_WAIT 2'h2
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACT_A_CTRL   8'h00
`define ACT_A_RPT    8'h04
`define ACT_A_PRE    8'h08
`define ACT_A_ACQ    8'h0C
`define ACT_A_CAP    8'h10
`define ACT_A_SETP   8'h14
`define ACT_A_UTH    8'h18
`define ACT_A_LTH    8'h1C
`define ACT_A_RES    8'h20
`define ACT_A_PREV   8'h24
`define ACT_A_ACC    8'h28
`define ACT_A_FILT   8'h2C
`define ACT_A_ERR    8'h30
`define ACT_A_CNT    8'h34
`define ACT_A_STAT   8'h38
`define ACT_A_MASK   8'h3C
`define ACT_A_FLAG   8'h40
// ----------------------------------------
// Fields
// ----------------------------------------
`define ACT_C_GO     0
`define ACT_C_CONT   1
`define ACT_C_MODE   4:2
`define ACT_C_CALC   10:8
`define ACT_C_TMD    14:12
`define ACT_C_CRS    18:16
`define ACT_S_DONE   0
`define ACT_S_THR    1
`define ACT_F_UTH    0
`define ACT_F_LTH    1
`define ACT_F_AOV    2
// ----------------------------------------
// Computation modes
// ----------------------------------------
`define ACT_M_BASIC  3'h0
`define ACT_M_ACCUM  3'h1
`define ACT_M_AVG    3'h2
`define ACT_M_BURST  3'h3
`define ACT_M_LPF    3'h4
`endif

// ---- logic/act_pkg.sv ----
/*
 Types of the converter compute and threshold unit.
 Assumes act_cfg.svh supplies the widths.
*/
`include "act_cfg.svh"
package act_pkg;
	typedef enum logic [2:0] {
		ACT_IDLE, ACT_PRE, ACT_ACQ, ACT_CONV, ACT_FIN, ACT_RETRIG
	} act_state_type;

	typedef struct packed {
		act_state_type          st;
		logic                   go;
		logic                   cont;
		logic [2:0]             mode;
		logic [2:0]             calc;
		logic [2:0]             tmd;
		logic [2:0]             crs;
		logic [7:0]             rpt;
		logic [7:0]             pre;
		logic [7:0]             acq;
		logic [4:0]             cap;
		logic [`ACT_DW-1:0]     setp;
		logic [`ACT_DW-1:0]     uth;
		logic [`ACT_DW-1:0]     lth;
		logic [`ACT_RES_W-1:0]  res;
		logic [`ACT_RES_W-1:0]  prev;
		logic [`ACT_ACC_W-1:0]  acc;
		logic [`ACT_DW-1:0]     filt;
		logic [`ACT_DW-1:0]     err;
		logic [7:0]             cnt;
		logic [1:0]             stat;
		logic [1:0]             mask;
		logic                   uflag;
		logic                   lflag;
		logic                   aov;
		logic [7:0]             tcnt;
		logic [1:0]             div;
		logic [3:0]             bitn;
		logic [1:0]             wt;
		logic [`ACT_RES_W-1:0]  sar;
		logic [`ACT_RES_W-1:0]  trial;
		logic                   s1;
		logic                   s2;
		logic [4:0]             cap_o;
		logic                   pch_o;
		logic                   smp_o;
		logic                   cnv_o;
		logic                   irq_o;
		logic [31:0]            rdata;
		logic                   perr;
	} act_reg_type;
endpackage

// ---- logic/act_unit.sv ----
/*
 Converter compute and threshold unit: sequencing of precharge, acquisition
 and successive-approximation conversion, result accumulation and filtering,
 error calculation, threshold test and interrupt, APB register file.
 Assumes a comparator input from the analog front end (asynchronous) and an
 APB master on the same clock.
*/
`timescale 1ns/1ps
`include "act_cfg.svh"

module act_unit
	import act_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`ACT_AW-1:0]    paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  cmp_in,
	output logic      [`ACT_RES_W-1:0] dac_code,
	output logic                       precharge,
	output logic                       sample,
	output logic                       converting,
	output logic      [4:0]            extra_cap,
	output logic                       irq
);
	act_reg_type           q;
	act_reg_type           n;
	logic [`ACT_ACC_W:0]   sum;
	logic [`ACT_ACC_W-1:0] lp;
	logic [`ACT_DW-1:0]    nf;
	logic [`ACT_DW-1:0]    err_c;
	logic [`ACT_DW-1:0]    cur;
	logic [7:0]            ncnt;
	logic [31:0]           rd;
	logic [1:0]            ev;
	logic [1:0]            clr;
	logic                  ok;
	logic                  tick;
	logic                  cmp_c;
	logic                  cond_c;
	logic                  aov_c;
	logic                  done_c;
	logic                  wr;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`ACT_DW-1:0] ext(input logic [`ACT_RES_W-1:0] r);
		return {{(`ACT_DW-`ACT_RES_W){1'b0}}, r};
	endfunction

	function automatic logic [`ACT_DW-1:0] shr(input logic [`ACT_ACC_W-1:0] x,
	                                           input logic [2:0] s);
		logic [`ACT_ACC_W-1:0] t;
		t = x >> s;
		return t[`ACT_DW-1:0];
	endfunction

	function automatic act_state_type first(input logic [7:0] p, input logic [7:0] a);
		if (p != 8'h00)
			return ACT_PRE;
		if (a != 8'h00)
			return ACT_ACQ;
		return ACT_CONV;
	endfunction

	function automatic logic thr(input logic [2:0] m, input logic [`ACT_DW-1:0] e,
	                             input logic [`ACT_DW-1:0] u,
	                             input logic [`ACT_DW-1:0] l);
		logic signed [`ACT_DW-1:0] se;
		logic signed [`ACT_DW-1:0] su;
		logic signed [`ACT_DW-1:0] sl;
		se = e;
		su = u;
		sl = l;
		unique case (m)
			3'h0: return 1'b0;
			3'h1: return se < sl;
			3'h2: return se >= sl;
			3'h3: return (se >= sl) && (se <= su);
			3'h4: return (se < sl) || (se > su);
			3'h5: return se <= su;
			3'h6: return se > su;
			3'h7: return 1'b1;
		endcase
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = q;
		n.s1 = cmp_in;
		n.s2 = q.s1;
		ev = 2'h0;
		clr = 2'h0;
		cmp_c = 1'b0;
		cond_c = 1'b0;
		err_c = '0;
		nf = '0;
		cur = ext(q.sar);
		sum = {1'b0, q.acc} + {{(`ACT_ACC_W+1-`ACT_RES_W){1'b0}}, q.sar};
		lp = q.acc + {{(`ACT_ACC_W-`ACT_RES_W){1'b0}}, q.sar} - (q.acc >> q.crs);
		ncnt = (q.cnt == 8'hFF) ? q.cnt : q.cnt + 8'h01;
		done_c = ncnt >= q.rpt;
		tick = q.div == `ACT_DIV_LAST;
		n.div = tick ? 2'h0 : q.div + 2'h1;
		wr = psel && penable && pwrite && !q.perr;
		ok = 1'b1;
		rd = '0;
		unique case (paddr)
			`ACT_A_CTRL: begin
				rd[`ACT_C_GO] = q.go;
				rd[`ACT_C_CONT] = q.cont;
				rd[`ACT_C_MODE] = q.mode;
				rd[`ACT_C_CALC] = q.calc;
				rd[`ACT_C_TMD] = q.tmd;
				rd[`ACT_C_CRS] = q.crs;
			end
			`ACT_A_RPT:  rd[7:0] = q.rpt;
			`ACT_A_PRE:  rd[7:0] = q.pre;
			`ACT_A_ACQ:  rd[7:0] = q.acq;
			`ACT_A_CAP:  rd[4:0] = q.cap;
			`ACT_A_SETP: rd[`ACT_DW-1:0] = q.setp;
			`ACT_A_UTH:  rd[`ACT_DW-1:0] = q.uth;
			`ACT_A_LTH:  rd[`ACT_DW-1:0] = q.lth;
			`ACT_A_RES:  rd[`ACT_RES_W-1:0] = q.res;
			`ACT_A_PREV: rd[`ACT_RES_W-1:0] = q.prev;
			`ACT_A_ACC:  rd[`ACT_ACC_W-1:0] = q.acc;
			`ACT_A_FILT: rd[`ACT_DW-1:0] = q.filt;
			`ACT_A_ERR:  rd[`ACT_DW-1:0] = q.err;
			`ACT_A_CNT:  rd[7:0] = q.cnt;
			`ACT_A_STAT: rd[1:0] = q.stat;
			`ACT_A_MASK: rd[1:0] = q.mask;
			`ACT_A_FLAG: rd[2:0] = {q.aov, q.lflag, q.uflag};
			default:     ok = 1'b0;
		endcase
		if (psel && !penable) begin
			n.rdata = rd;
			n.perr = !ok;
		end
		if (wr) begin
			unique case (paddr)
				`ACT_A_CTRL: begin
					if (q.st == ACT_IDLE)
						n.go = pwdata[`ACT_C_GO];
					n.cont = pwdata[`ACT_C_CONT];
					n.mode = pwdata[`ACT_C_MODE];
					n.calc = pwdata[`ACT_C_CALC];
					n.tmd = pwdata[`ACT_C_TMD];
					n.crs = pwdata[`ACT_C_CRS];
				end
				`ACT_A_RPT:  n.rpt = pwdata[7:0];
				`ACT_A_PRE:  n.pre = pwdata[7:0];
				`ACT_A_ACQ:  n.acq = pwdata[7:0];
				`ACT_A_CAP:  n.cap = pwdata[4:0];
				`ACT_A_SETP: n.setp = pwdata[`ACT_DW-1:0];
				`ACT_A_UTH:  n.uth = pwdata[`ACT_DW-1:0];
				`ACT_A_LTH:  n.lth = pwdata[`ACT_DW-1:0];
				`ACT_A_STAT: clr = pwdata[1:0];
				`ACT_A_MASK: n.mask = pwdata[1:0];
				`ACT_A_FLAG: begin
					n.uflag = q.uflag & ~pwdata[`ACT_F_UTH];
					n.lflag = q.lflag & ~pwdata[`ACT_F_LTH];
					n.aov = q.aov & ~pwdata[`ACT_F_AOV];
				end
				default: ;
			endcase
		end
		aov_c = n.aov;
		// ----------------------------------------
		// Sequencer
		// ----------------------------------------
		unique case (q.st)
			ACT_IDLE: begin
				if (q.go)
					n.st = first(q.pre, q.acq);
			end
			ACT_PRE: begin
				if (tick) begin
					n.tcnt = q.tcnt - 8'h01;
					if (q.tcnt == 8'h01)
						n.st = (q.acq != 8'h00) ? ACT_ACQ : ACT_CONV;
				end
			end
			ACT_ACQ: begin
				if (tick) begin
					n.tcnt = q.tcnt - 8'h01;
					if (q.tcnt == 8'h01)
						n.st = ACT_CONV;
				end
			end
			ACT_CONV: begin
				if (q.wt != 2'h0) begin
					n.wt = q.wt - 2'h1;
				end else begin
					if (q.s2)
						n.sar = q.trial;
					if (q.bitn == 4'h0) begin
						n.st = ACT_FIN;
					end else begin
						n.bitn = q.bitn - 4'h1;
						n.wt = `ACT_BIT_WAIT;
					end
				end
			end
			ACT_FIN: begin
				n.res = q.sar;
				n.prev = q.res;
				n.go = 1'b0;
				ev[`ACT_S_DONE] = 1'b1;
				unique case (q.mode)
					`ACT_M_ACCUM: begin
						n.acc = sum[`ACT_ACC_W-1:0];
						aov_c = aov_c | sum[`ACT_ACC_W];
						n.cnt = ncnt;
						nf = shr(sum[`ACT_ACC_W-1:0], q.crs);
						cmp_c = 1'b1;
					end
					`ACT_M_AVG, `ACT_M_BURST: begin
						n.acc = sum[`ACT_ACC_W-1:0];
						aov_c = aov_c | sum[`ACT_ACC_W];
						n.cnt = ncnt;
						if (done_c) begin
							nf = shr(sum[`ACT_ACC_W-1:0], q.crs);
							cmp_c = 1'b1;
							n.acc = '0;
							n.cnt = 8'h00;
						end
					end
					`ACT_M_LPF: begin
						n.acc = lp;
						n.cnt = ncnt;
						if (done_c) begin
							nf = shr(lp, q.crs);
							cmp_c = 1'b1;
							n.cnt = 8'h00;
						end
					end
					default: begin
						n.acc = {{(`ACT_ACC_W-`ACT_RES_W){1'b0}}, q.sar};
						nf = cur;
						cmp_c = 1'b1;
					end
				endcase
				if (cmp_c) begin
					unique case (q.calc)
						3'h0: err_c = cur - ext(q.res);
						3'h1: err_c = cur - ext(q.res);
						3'h2: err_c = cur - q.setp;
						3'h3: err_c = cur - nf;
						3'h4: err_c = nf - q.filt;
						3'h5: err_c = nf - q.setp;
						default: err_c = '0;
					endcase
					cond_c = thr(q.tmd, err_c, q.uth, q.lth);
					n.uflag = $signed(err_c) > $signed(q.uth);
					n.lflag = $signed(err_c) < $signed(q.lth);
					ev[`ACT_S_THR] = cond_c || aov_c;
					n.filt = nf;
					n.err = err_c;
				end
				if (q.cont || (q.mode == `ACT_M_BURST && !done_c))
					n.st = ACT_RETRIG;
				else
					n.st = ACT_IDLE;
			end
			ACT_RETRIG: begin
				n.go = 1'b1;
				n.st = first(q.pre, q.acq);
			end
		endcase
		n.aov = aov_c;
		if (n.st != q.st) begin
			n.div = 2'h0;
			n.tcnt = (n.st == ACT_PRE) ? q.pre : q.acq;
			n.bitn = `ACT_BIT_MSB;
			n.wt = `ACT_BIT_WAIT;
			if (n.st == ACT_CONV)
				n.sar = '0;
		end
		n.stat = (q.stat & ~clr) | ev;
		n.irq_o = |(n.stat & n.mask);
		n.trial = n.sar | ({{(`ACT_RES_W-1){1'b0}}, 1'b1} << n.bitn);
		n.pch_o = n.st == ACT_PRE;
		n.smp_o = n.st == ACT_ACQ;
		n.cnv_o = n.st == ACT_CONV;
		n.cap_o = (n.st == ACT_PRE || n.st == ACT_ACQ) ? n.cap : 5'h00;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			q <= '0;
		else
			q <= n;
	end

	assign prdata = q.rdata;
	assign pslverr = q.perr && psel && penable;
	assign pready = psel && penable;
	assign dac_code = q.trial;
	assign precharge = q.pch_o;
	assign sample = q.smp_o;
	assign converting = q.cnv_o;
	assign extra_cap = q.cap_o;
	assign irq = q.irq_o;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [10:0] plen_q;
	always_ff @(posedge clk) begin
		if (!resetn)
			plen_q <= '0;
		else
			plen_q <= (q.st == ACT_PRE) ? plen_q + 11'h001 : 11'h000;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence fin_s;
		q.st == ACT_FIN;
	endsequence
	sequence retrig_s;
		q.st == ACT_RETRIG && !q.go ##1 q.go && q.st != ACT_IDLE;
	endsequence

	burst_retrig_a: assert property (fin_s and (q.mode == `ACT_M_BURST && !done_c)
		|=> retrig_s) else $error("burst did not retrigger");
	done_load_a: assert property (fin_s |=> !q.go && q.stat[`ACT_S_DONE]
		&& q.res == $past(q.sar)) else $error("end of conversion not latched");
	cap_conv_a: assert property (q.cnv_o |-> q.cap_o == 5'h00)
		else $error("extra cap connected in conversion");
	pre_len_a: assert property ((q.st == ACT_PRE && n.st != ACT_PRE)
		|-> plen_q == {1'b0, q.pre, 2'b00} - 11'h001) else $error("precharge length wrong");
	zero_skip_a: assert property ((q.st == ACT_IDLE && q.go && q.pre == 8'h00
		&& q.acq == 8'h00) |=> q.st == ACT_CONV) else $error("conversion not immediate");
	thr_irq_a: assert property ((cmp_c && cond_c) |=> q.stat[`ACT_S_THR])
		else $error("threshold flag not set");
	aov_irq_a: assert property ((q.st == ACT_FIN && cmp_c && aov_c)
		|=> q.stat[`ACT_S_THR]) else $error("overflow did not interrupt");
	lth_flag_a: assert property (cmp_c |=> q.lflag == ($signed(q.err) < $signed(q.lth)))
		else $error("lower flag wrong");
	hold_res_a: assert property ((q.st != ACT_FIN) |=> $stable(q.res))
		else $error("result changed outside update");
endmodule

// ---- tb/act_afe_model.sv ----
/*
 Analog front end model: comparator against the trial code.
 Assumes the unit's dac_code and converting outputs, input level from bench.
*/
`timescale 1ns/1ps
module act_afe_model
	import act_pkg::*;
(
	input  logic       clk,
	input  logic [9:0] dac_code,
	input  logic       converting,
	input  logic [9:0] vin,
	output logic       cmp_in
);
	// ----------------------------------------
	// Comparator, meaningless outside conversion
	// ----------------------------------------
	logic tog_q = 1'h0;
	always @(posedge clk) begin
		tog_q <= ~tog_q;
	end
	assign cmp_in = converting ? (vin >= dac_code) : tog_q;
endmodule

// ---- tb/tb_act_unit.sv ----
/*
 Self-checking bench of the compute and threshold unit over APB.
 Assumes act_cfg.svh offsets and zero-wait APB answers.
*/
`timescale 1ns/1ps
`include "act_cfg.svh"
module tb_act_unit
	import act_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        cmp_in, precharge, sample, converting, irq, perr, cv_q;
	logic [7:0]  paddr, exp_t;
	logic [31:0] pwdata, prdata, r;
	logic [9:0]  dac_code, vin;
	logic [4:0]  extra_cap, cap_e;
	int          fail_count = 0, cmp_count = 0, cyc = 0, k0;
	int          pch_n = 0, smp_n = 0, conv_f = 0, cap_bad = 0, dac_bad = 0;

	act_unit dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .dac_code(dac_code),
		.precharge(precharge), .sample(sample), .converting(converting),
		.extra_cap(extra_cap), .irq(irq));
	act_afe_model afe_u (.clk(clk), .dac_code(dac_code), .converting(converting),
		.vin(vin), .cmp_in(cmp_in));

	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Monitors and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (precharge === 1'h1) pch_n++;
		if (sample === 1'h1) smp_n++;
		if (cv_q === 1'h1 && converting === 1'h0) conv_f++;
		if (cv_q === 1'h0 && converting === 1'h1 && dac_code !== 10'h200) dac_bad++;
		cv_q = converting;
		if ((precharge === 1'h1 || sample === 1'h1) && extra_cap !== cap_e) cap_bad++;
		if (converting === 1'h1 && extra_cap !== 5'h00) cap_bad++;
		if (cyc == 30000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		r = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(r & m, e);
	endtask

	task run(input logic [31:0] w, input int n);
		int t;
		wr(`ACT_A_CTRL, w);
		t = conv_f + n;
		while (conv_f < t) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [31:0] mk(input logic c, input logic [2:0] md, cl, tm, cr);
		mk = {13'h0, cr, 1'h0, tm, 1'h0, cl, 3'h0, md, c, 1'h1};
	endfunction

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, cv_q} = '0;
		vin = 10'h155;
		cap_e = 5'h00;
		exp_t = 8'hB2;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		rc(`ACT_A_CTRL, 32'hFFFFFFFF, 32'h0);
		apb(1'h0, 8'h44, 32'h0);
		chk(r, 32'h0);
		chk(perr, 32'h1);
		wr(`ACT_A_MASK, 32'h2);
		run(mk(1'h0, 3'h0, 3'h0, 3'h0, 3'h0), 1);
		chk(pch_n + smp_n, 32'h0);
		rc(`ACT_A_RES, 32'hFFFFFFFF, 32'h155);
		rc(`ACT_A_STAT, 32'h1, 32'h1);
		rc(`ACT_A_CTRL, 32'h1, 32'h0);
		repeat (20) @(posedge clk);
		rc(`ACT_A_RES, 32'hFFFFFFFF, 32'h155);
		$display("test plain conversion done");
		cap_e = 5'h15;
		wr(`ACT_A_PRE, 32'h3);
		wr(`ACT_A_ACQ, 32'h2);
		wr(`ACT_A_CAP, 32'h15);
		run(mk(1'h0, 3'h0, 3'h0, 3'h0, 3'h0), 1);
		chk(pch_n, 32'hC);
		chk(smp_n, 32'h8);
		chk(cap_bad, 32'h0);
		wr(`ACT_A_PRE, 32'h0);
		wr(`ACT_A_ACQ, 32'h0);
		$display("test timed sampling done");
		vin = 10'h100;
		wr(`ACT_A_SETP, 32'h200);
		wr(`ACT_A_UTH, 32'h10);
		wr(`ACT_A_LTH, 32'hFF80);
		for (int m = 0; m < 8; m++) begin
			wr(`ACT_A_STAT, 32'h3);
			run(mk(1'h0, 3'h0, 3'h2, 3'(m), 3'h0), 1);
			rc(`ACT_A_STAT, 32'h2, {30'h0, exp_t[m], 1'h0});
			chk(irq, exp_t[m]);
		end
		rc(`ACT_A_ERR, 32'hFFFFFFFF, 32'hFF00);
		rc(`ACT_A_FLAG, 32'h3, 32'h2);
		vin = 10'h180;
		run(mk(1'h0, 3'h0, 3'h0, 3'h0, 3'h0), 1);
		rc(`ACT_A_ERR, 32'hFFFFFFFF, 32'h80);
		run(mk(1'h0, 3'h0, 3'h6, 3'h0, 3'h0), 1);
		rc(`ACT_A_ERR, 32'hFFFFFFFF, 32'h0);
		$display("test thresholds done");
		vin = 10'h000;
		run(mk(1'h0, 3'h0, 3'h0, 3'h0, 3'h0), 1);
		rc(`ACT_A_ACC, 32'hFFFFFFFF, 32'h0);
		vin = 10'h0A0;
		wr(`ACT_A_RPT, 32'h4);
		repeat (4) run(mk(1'h0, 3'h2, 3'h0, 3'h0, 3'h2), 1);
		rc(`ACT_A_FILT, 32'hFFFFFFFF, 32'hA0);
		rc(`ACT_A_CNT, 32'hFFFFFFFF, 32'h0);
		vin = 10'h0C8;
		wr(`ACT_A_SETP, 32'hA0);
		wr(`ACT_A_STAT, 32'h3);
		k0 = conv_f;
		run(mk(1'h0, 3'h3, 3'h5, 3'h6, 3'h2), 4);
		repeat (60) @(posedge clk);
		chk(conv_f - k0, 32'h4);
		rc(`ACT_A_FILT, 32'hFFFFFFFF, 32'hC8);
		rc(`ACT_A_ERR, 32'hFFFFFFFF, 32'h28);
		rc(`ACT_A_STAT, 32'h2, 32'h2);
		$display("test average and burst done");
		vin = 10'h100;
		wr(`ACT_A_RPT, 32'h1);
		run(mk(1'h0, 3'h4, 3'h0, 3'h0, 3'h1), 1);
		rc(`ACT_A_FILT, 32'hFFFFFFFF, 32'h80);
		run(mk(1'h0, 3'h4, 3'h0, 3'h0, 3'h1), 1);
		rc(`ACT_A_FILT, 32'hFFFFFFFF, 32'hC0);
		$display("test low-pass done");
		wr(`ACT_A_STAT, 32'h3);
		wr(`ACT_A_FLAG, 32'h7);
		vin = 10'h3FF;
		run(mk(1'h1, 3'h1, 3'h0, 3'h0, 3'h0), 258);
		run(32'h0, 1);
		rc(`ACT_A_FLAG, 32'h4, 32'h4);
		rc(`ACT_A_STAT, 32'h2, 32'h2);
		$display("test overflow done");
		chk(dac_bad, 32'h0);
		report_and_stop();
	end
endmodule
